// file: src/io_status_output_regs.sv
// io status bank: slot error flags, heartbeat, output switch states
//
// Behaviour
// - Low four bits of the error word flag a bus error per slot, bit 0 base slot.
// - The heartbeat counter adds one on every host-to-network transfer.
// - The heartbeat runs 1 to 65535 then wraps to 1, never zero while counting.
// - Output word bit 0 drives channel one, bit 1 channel two; one means on.
//
// The plain strobed port is this design's own decision.
module io_status_output_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    // slot error pins, asynchronous, one per slot
    input wire logic [3:0] slotBusError,
    // transfer event from the network side, same clock
    input wire logic transferDone,
    // open-drain outputs: enable high sinks to the return node
    output logic outputChannelOneOe,
    output logic outputChannelTwoOe,
    // interrupt
    output logic irq
);
    iosr_pkg::iosr_bus_type bus;
    logic [3:0] errSync;
    logic [15:0] hbCount;
    logic hbWrap;

    logic [3:0] err_q, err_d;
    logic [1:0] out_q, out_d;
    logic [15:0] rdata_q, rdata_d;
    logic [4:0] irqSt_q, irqSt_d;
    logic [4:0] irqMask_q, irqMask_d;
    logic irq_q, irq_d;
    logic [4:0] events;

    assign bus.addr = regAddr;
    assign bus.wdata = regWdata;
    assign bus.write = regWrite;
    assign bus.read = regRead;

    iosr_sync #(.WIDTH(iosr_pkg::SLOT_COUNT)) uSync (
        .clock(clock),
        .rst(rst),
        .async(slotBusError),
        .synced(errSync)
    );

    iosr_heartbeat uHeartbeat (
        .clock(clock),
        .rst(rst),
        .transferPulse(transferDone),
        .count(hbCount),
        .wrapPulse(hbWrap)
    );

    function automatic logic hit(input iosr_pkg::iosr_bus_type b,
                                 input logic [15:0] a);
        hit = (b.addr == a);
    endfunction

    // error flags follow the live slot errors; rising edges raise events
    always_comb begin
        err_d = errSync;
        events = '0;
        events[iosr_pkg::IRQ_ERR_LSB +: 4] = errSync & ~err_q;
        events[iosr_pkg::IRQ_HB_WRAP_BIT] = hbWrap;
    end

    // software-writable output states and mask
    always_comb begin
        out_d = out_q;
        irqMask_d = irqMask_q;
        if (bus.write && hit(bus, iosr_pkg::ADDR_OUT_STATES)) begin
            out_d = bus.wdata[1:0];
        end
        if (bus.write && hit(bus, iosr_pkg::ADDR_IRQ_MASK)) begin
            irqMask_d = bus.wdata[4:0];
        end
    end

    // sticky status: read clears, a same-cycle event still sets
    always_comb begin
        irqSt_d = irqSt_q;
        if (bus.read && hit(bus, iosr_pkg::ADDR_IRQ_STATUS)) begin
            irqSt_d = '0;
        end
        irqSt_d = irqSt_d | events;
        irq_d = |(irqSt_d & irqMask_d);
    end

    // read mux; unmapped addresses and reserved holes read zero
    always_comb begin
        rdata_d = '0;
        if (bus.read) begin
            case (bus.addr)
                iosr_pkg::ADDR_ERR_FLAGS: rdata_d = {12'h000, err_q};
                iosr_pkg::ADDR_HEARTBEAT: rdata_d = hbCount;
                iosr_pkg::ADDR_OUT_STATES: rdata_d = {14'h0000, out_q};
                iosr_pkg::ADDR_IRQ_STATUS: rdata_d = {11'h000, irqSt_q};
                iosr_pkg::ADDR_IRQ_MASK: rdata_d = {11'h000, irqMask_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            err_q <= iosr_pkg::ERR_RESET;
            out_q <= iosr_pkg::OUT_RESET;
            rdata_q <= '0;
            irqSt_q <= '0;
            irqMask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            err_q <= err_d;
            out_q <= out_d;
            rdata_q <= rdata_d;
            irqSt_q <= irqSt_d;
            irqMask_q <= irqMask_d;
            irq_q <= irq_d;
        end
    end

    assign regRdata = rdata_q;
    assign outputChannelOneOe = out_q[iosr_pkg::CHAN_ONE_BIT];
    assign outputChannelTwoOe = out_q[iosr_pkg::CHAN_TWO_BIT];
    assign irq = irq_q;
endmodule

// file: src/iosr_pkg.sv
// package: register map, field positions and carriers for the io status bank
package iosr_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [15:0] ADDR_ERR_FLAGS = 16'h7593;
    localparam logic [15:0] ADDR_HEARTBEAT = 16'h7594;
    localparam logic [15:0] ADDR_OUT_STATES = 16'h9C41;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'h9C50;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h9C51;
    localparam int SLOT_COUNT = 4;
    localparam int CHAN_ONE_BIT = 0;
    localparam int CHAN_TWO_BIT = 1;
    localparam logic [15:0] HB_RESET = 16'h0000;
    localparam logic [15:0] HB_FIRST = 16'h0001;
    localparam logic [15:0] HB_LAST = 16'hFFFF;
    localparam logic [1:0] OUT_RESET = 2'h0;
    localparam logic [3:0] ERR_RESET = 4'h0;
    localparam int IRQ_ERR_LSB = 0;
    localparam int IRQ_HB_WRAP_BIT = 4;
    localparam int IRQ_W = 5;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic write;
        logic read;
    } iosr_bus_type;
endpackage

// file: src/iosr_heartbeat.sv
// heartbeat counter: 1..65535 then back to 1, zero only after reset
module iosr_heartbeat (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // transfer event
    input wire logic transferPulse,
    // state
    output logic [15:0] count,
    output logic wrapPulse
);
    logic [15:0] count_q, count_d;
    logic wrap_q, wrap_d;

    always_comb begin
        count_d = count_q;
        wrap_d = 1'b0;
        if (transferPulse) begin
            if (count_q == iosr_pkg::HB_LAST) begin
                count_d = iosr_pkg::HB_FIRST;
                wrap_d = 1'b1;
            end else begin
                count_d = count_q + iosr_pkg::HB_FIRST;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= iosr_pkg::HB_RESET;
            wrap_q <= 1'b0;
        end else begin
            count_q <= count_d;
            wrap_q <= wrap_d;
        end
    end

    assign count = count_q;
    assign wrapPulse = wrap_q;
endmodule

// file: src/iosr_sync.sv
// two-flop synchroniser for a bus of pin levels
module iosr_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // levels
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_q, sync_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async;
            sync_q <= meta_q;
        end
    end

    assign synced = sync_q;
endmodule

// file: sim/iosr_assertions.sv
// checker: port relations of the io status bank
module iosr_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // watched ports
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdata,
    input wire logic transferDone,
    input wire logic outputChannelOneOe,
    input wire logic outputChannelTwoOe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_hb;
        regRead && regAddr == iosr_pkg::ADDR_HEARTBEAT;
    endsequence
    chk_out_follow: assert property (regWrite && regAddr ==
        iosr_pkg::ADDR_OUT_STATES |=> {outputChannelTwoOe,
        outputChannelOneOe} == $past(regWdata[1:0]))
        else $error("output state mismatch");
    chk_err_upper: assert property (regRead && regAddr ==
        iosr_pkg::ADDR_ERR_FLAGS |=> regRdata[15:4] == 12'h000)
        else $error("error word upper bits set");
    chk_hb_nonzero: assert property (transferDone ##1 s_hb |=>
        regRdata != 16'h0000) else $error("heartbeat read zero");
    chk_hb_hold: assert property (s_hb ##0 !transferDone ##1
        !transferDone ##1 s_hb |=> regRdata == $past(regRdata, 2))
        else $error("heartbeat moved without transfer");
    chk_reset_quiet: assert property ($fell(rst) |->
        !outputChannelOneOe && !outputChannelTwoOe && !irq)
        else $error("outputs not clear after reset");
endmodule

// file: sim/iosr_host.sv
// host model: register port master
module iosr_host (
    // clock
    input wire logic clock,
    // register port
    output logic [15:0] regAddr,
    output logic [15:0] regWdata,
    output logic regWrite,
    output logic regRead,
    input wire logic [15:0] regRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {regAddr, regWdata, regWrite, regRead} = 34'h0;
    // only mapped or far-off addresses, never the reserved span
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        // idle edge so a following strobe never lands in the same step
        @(posedge clock);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        // data stand for the one cycle after the strobe edge only
        @(posedge clock);
        d = regRdata;
    endtask
endmodule

// file: sim/tb_top.sv
// top bench of the io status bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] slotBusError = 4'h0;
    logic transferDone = 1'b0;
    logic [15:0] regAddr, regWdata, regRdata, rd;
    logic regWrite, regRead, outputChannelOneOe, outputChannelTwoOe, irq;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    // rows: expected channel bits above the written word
    logic [17:0] rows [4] = '{18'h00000, 18'h10001, 18'h20002, 18'h3FFFF};
    io_status_output_regs u_io_status_output_regs (.clock, .rst, .regAddr,
        .regWdata, .regWrite, .regRead, .regRdata, .slotBusError,
        .transferDone, .outputChannelOneOe, .outputChannelTwoOe, .irq);
    iosr_host u_iosr_host (.clock, .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata);
    always #20 clock = ~clock;
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // high for n edges gives n transfers
    task automatic pulse(input int n);
        transferDone <= 1'b1;
        repeat (n) @(posedge clock);
        transferDone <= 1'b0;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        cmp({14'h0, outputChannelTwoOe, outputChannelOneOe}, 16'h0);
        u_iosr_host.rd(iosr_pkg::ADDR_HEARTBEAT, rd);
        cmp(rd, iosr_pkg::HB_RESET);
        u_iosr_host.rd(iosr_pkg::ADDR_HEARTBEAT, rd);
        cmp(rd, iosr_pkg::HB_RESET);
        $display("reset test done");
        foreach (rows[i]) begin
            u_iosr_host.wr(iosr_pkg::ADDR_OUT_STATES, rows[i][15:0]);
            cmp({14'h0, outputChannelTwoOe, outputChannelOneOe},
                {14'h0, rows[i][17:16]});
            u_iosr_host.rd(iosr_pkg::ADDR_OUT_STATES, rd);
            cmp(rd, {14'h0, rows[i][17:16]});
        end
        $display("output table done");
        u_iosr_host.wr(iosr_pkg::ADDR_IRQ_MASK, 16'h001F);
        slotBusError <= 4'h9;
        // two sync flops plus the register
        repeat (4) @(posedge clock);
        u_iosr_host.rd(iosr_pkg::ADDR_ERR_FLAGS, rd);
        cmp(rd, 16'h0009);
        cmp({15'h0, irq}, 16'h0001);
        u_iosr_host.rd(iosr_pkg::ADDR_IRQ_STATUS, rd);
        cmp(rd, 16'h0009);
        cmp({15'h0, irq}, 16'h0000);
        u_iosr_host.rd(16'h1234, rd);
        cmp(rd, 16'h0000);
        $display("error and interrupt test done");
        pulse(1);
        u_iosr_host.rd(iosr_pkg::ADDR_HEARTBEAT, rd);
        cmp(rd, iosr_pkg::HB_FIRST);
        pulse(65534);
        u_iosr_host.rd(iosr_pkg::ADDR_HEARTBEAT, rd);
        cmp(rd, iosr_pkg::HB_LAST);
        pulse(1);
        u_iosr_host.rd(iosr_pkg::ADDR_HEARTBEAT, rd);
        cmp(rd, iosr_pkg::HB_FIRST);
        // the wrap raises status bit 4, unmasked since the mask is all ones
        cmp({15'h0, irq}, 16'h0001);
        u_iosr_host.rd(iosr_pkg::ADDR_IRQ_STATUS, rd);
        cmp(rd, 16'h0010);
        cmp({15'h0, irq}, 16'h0000);
        $display("heartbeat wrap test done");
        close_out();
    end
endmodule
bind io_status_output_regs iosr_assertions u_iosr_assertions (.clock,
    .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .transferDone, .outputChannelOneOe, .outputChannelTwoOe, .irq);
